//--- hdl/uvpa_pkg.sv
package uvpa_pkg;
  // programming pulse figures
  localparam int CLOCK_HZ = 10_000_000;
  localparam int PULSE_US = 1000;
  localparam int PULSE_MIN_US = 950;
  localparam int PULSE_MAX_US = 1050;
  localparam int PULSE_CYCLES = PULSE_US * (CLOCK_HZ / 1_000_000);
  localparam int OVER_FACTOR = 4;
  localparam int MAX_PULSES = 15;
  localparam int CONV_PULSE_US = 50_000;
  localparam int CONV_PULSE_CYCLES = CONV_PULSE_US * (CLOCK_HZ / 1_000_000);
  // pin set-up gaps
  localparam int SETUP_US = 2;
  localparam int SETUP_CYCLES = SETUP_US * (CLOCK_HZ / 1_000_000);
  localparam int ACCESS_NS = 500;
  localparam int ACCESS_CYCLES = (ACCESS_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int ID_ADDR_BIT = 9;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  typedef enum logic [2:0] {
    UVPA_CMD_READ = 3'h0,
    UVPA_CMD_PROGRAM = 3'h1,
    UVPA_CMD_IDENT = 3'h2,
    UVPA_CMD_BLANK = 3'h3
  } uvpa_cmd_e;

  typedef enum logic [1:0] {
    UVPA_OK = 2'h0,
    UVPA_FAIL_VERIFY = 2'h1,
    UVPA_FAIL_IDENT = 2'h2
  } uvpa_status_e;

  function automatic logic odd_parity_ok(input logic [7:0] b);
    return ^b;
  endfunction
endpackage

//--- hdl/uvpa_sync.sv
`timescale 1ns/1ps
module uvpa_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_dout = dout;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_dout[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout <= next_dout;
    end
  end
endmodule

//--- hdl/uvpa_host.sv
`timescale 1ns/1ps
// Summary of operation
// - programming raises the programming supply and pulls the strobe low
// - read: chip enable low, output enable low, strobe high, normal supply
// - program: ce low, oe high, strobe low, supply high, host drives data
// - verify: ce low, oe low, strobe high, supply high, device drives byte
// - ident: address nine at id voltage, ce oe low, address zero low for maker and high for product, other addresses low
// - compare ident bytes with expected part before programming; host compares only in the ident command, programming does not wait on it
// - fast method: one-millisecond pulses, verify after each
// - each initial pulse lasts within one millisecond plus or minus five percent
// - after verify, overprogram pulse of four times the pulses used
// - at most fifteen pulses per byte, then report failure
// - overprogram length scales with the iteration counter
// - after programming, final read-back at normal supply levels
// - alternative: one fifty millisecond pulse per byte, no overprogram
module uvpa_host
  import uvpa_pkg::*;
#(
  parameter int ADDR_WIDTH = 14,
  parameter int PULSE_LEN = PULSE_CYCLES,
  parameter int CONV_LEN = CONV_PULSE_CYCLES,
  parameter logic [7:0] EXPECT_MAKER = 8'ha4, // arbitrary value, odd parity
  parameter logic [7:0] EXPECT_PRODUCT = 8'hb3 // arbitrary value, odd parity
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire uvpa_pkg::uvpa_cmd_e cmd,
  input wire logic cmd_conventional,
  input wire logic [ADDR_WIDTH-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic done,
  output logic [7:0] rdata,
  output uvpa_pkg::uvpa_status_e status,
  output logic [ADDR_WIDTH-1:0] addr,
  output logic id_voltage,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic program_strobe_n,
  output logic programming_supply,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] data_in
);
  import uvpa_pkg::*;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_SETUP = 8'h02,
    S_PULSE = 8'h04,
    S_GAP = 8'h08,
    S_SAMPLE = 8'h10,
    S_OVER = 8'h20,
    S_FINAL = 8'h40,
    S_DONE = 8'h80
  } uvpa_state_e;

  localparam int CW = 32;

  logic [7:0] din;
  uvpa_sync #(.WIDTH(8)) u_sync (
    .clock(clock),
    .reset(reset),
    .din(data_in),
    .dout(din)
  );

  uvpa_state_e state, next_state;
  logic [CW-1:0] count, next_count;
  logic [3:0] iter, next_iter;
  logic [1:0] phase, next_phase;
  uvpa_cmd_e op, next_op;
  logic conv, next_conv;
  logic [7:0] wbyte, next_wbyte;
  logic [7:0] maker, next_maker;
  logic next_cmd_ready, next_done, next_id_voltage, next_ce_n, next_oe_n;
  logic next_pgm_n, next_vpp, next_data_oe;
  logic [7:0] next_rdata;
  uvpa_status_e next_status;
  logic [ADDR_WIDTH-1:0] next_addr;
  logic [7:0] next_data_out;

  function automatic logic [CW-1:0] over_len(input logic [3:0] n);
    return CW'(OVER_FACTOR) * CW'(PULSE_LEN) * CW'(n);
  endfunction

  always_comb begin
    next_state = state;
    next_count = count;
    next_iter = iter;
    next_phase = phase;
    next_op = op;
    next_conv = conv;
    next_wbyte = wbyte;
    next_maker = maker;
    next_cmd_ready = 1'b0;
    next_done = 1'b0;
    next_rdata = rdata;
    next_status = status;
    next_addr = addr;
    next_id_voltage = id_voltage;
    next_ce_n = chip_enable_n;
    next_oe_n = output_enable_n;
    next_pgm_n = 1'b1;
    next_vpp = programming_supply;
    next_data_out = data_out;
    next_data_oe = data_oe;
    case (state)
      S_IDLE: begin
        next_cmd_ready = 1'b1;
        next_ce_n = 1'b1;
        next_oe_n = 1'b1;
        next_vpp = 1'b0;
        next_id_voltage = 1'b0;
        next_data_oe = 1'b0;
        if (cmd_valid && cmd_ready) begin
          next_cmd_ready = 1'b0;
          next_op = cmd;
          next_conv = cmd_conventional;
          next_wbyte = cmd_data;
          next_iter = 4'h0;
          next_phase = 2'h0;
          next_count = CW'(SETUP_CYCLES);
          next_state = S_SETUP;
          next_ce_n = 1'b0;
          if (cmd == UVPA_CMD_PROGRAM) begin
            next_addr = cmd_addr;
            next_vpp = 1'b1;
            next_data_out = cmd_data;
            next_data_oe = 1'b1;
          end else if (cmd == UVPA_CMD_IDENT) begin
            next_addr = '0;
            next_id_voltage = 1'b1;
            next_oe_n = 1'b0;
          end else begin
            next_addr = cmd_addr;
            next_oe_n = 1'b0;
          end
        end
      end
      S_SETUP: begin
        if (count > CW'(1)) begin
          next_count = count - CW'(1);
        end else if (op == UVPA_CMD_PROGRAM) begin
          next_pgm_n = 1'b0;
          next_count = conv ? CW'(CONV_LEN) : CW'(PULSE_LEN);
          next_iter = iter + 4'h1;
          next_state = S_PULSE;
        end else begin
          next_count = CW'(ACCESS_CYCLES);
          next_state = S_SAMPLE;
        end
      end
      S_PULSE: begin
        next_pgm_n = 1'b0;
        if (count > CW'(1)) begin
          next_count = count - CW'(1);
        end else begin
          next_pgm_n = 1'b1;
          next_data_oe = 1'b0;
          next_count = CW'(SETUP_CYCLES);
          next_state = S_GAP;
        end
      end
      S_GAP: begin
        if (count > CW'(1)) begin
          next_count = count - CW'(1);
        end else if (phase == 2'h1) begin
          next_state = S_FINAL;
          next_vpp = 1'b0;
          next_count = CW'(SETUP_CYCLES);
        end else begin
          next_oe_n = 1'b0;
          next_count = CW'(ACCESS_CYCLES);
          next_state = S_SAMPLE;
        end
      end
      S_SAMPLE: begin
        if (count > CW'(1)) begin
          next_count = count - CW'(1);
        end else begin
          next_rdata = din;
          next_status = UVPA_OK;
          next_state = S_DONE;
          if (op == UVPA_CMD_BLANK && din != ERASED_BYTE) begin
            next_status = UVPA_FAIL_VERIFY;
          end else if (op == UVPA_CMD_IDENT && phase == 2'h0) begin
            next_maker = din;
            next_addr = ADDR_WIDTH'(1);
            next_count = CW'(ACCESS_CYCLES);
            next_phase = 2'h1;
            next_state = S_SAMPLE;
          end else if (op == UVPA_CMD_IDENT) begin
            if (maker != EXPECT_MAKER || din != EXPECT_PRODUCT ||
                !odd_parity_ok(maker) || !odd_parity_ok(din)) begin
              next_status = UVPA_FAIL_IDENT;
            end
          end else if (op == UVPA_CMD_PROGRAM && phase == 2'h2) begin
            if (din != wbyte) begin
              next_status = UVPA_FAIL_VERIFY;
            end
          end else if (op == UVPA_CMD_PROGRAM) begin
            next_oe_n = 1'b1;
            if (din == wbyte) begin
              if (conv) begin
                next_state = S_GAP;
                next_phase = 2'h1;
                next_count = CW'(1);
              end else begin
                next_pgm_n = 1'b0;
                next_data_oe = 1'b1;
                next_count = over_len(iter);
                next_state = S_OVER;
              end
            end else if (conv || iter == 4'(MAX_PULSES)) begin
              next_status = UVPA_FAIL_VERIFY;
              next_vpp = 1'b0;
            end else begin
              next_data_oe = 1'b1;
              next_pgm_n = 1'b0;
              next_iter = iter + 4'h1;
              next_count = CW'(PULSE_LEN);
              next_state = S_PULSE;
            end
          end
        end
      end
      S_OVER: begin
        next_pgm_n = 1'b0;
        next_data_oe = 1'b1;
        if (count > CW'(1)) begin
          next_count = count - CW'(1);
        end else begin
          next_pgm_n = 1'b1;
          next_data_oe = 1'b0;
          next_phase = 2'h1;
          next_count = CW'(SETUP_CYCLES);
          next_state = S_GAP;
        end
      end
      S_FINAL: begin
        if (count > CW'(1)) begin
          next_count = count - CW'(1);
        end else begin
          next_oe_n = 1'b0;
          next_phase = 2'h2;
          next_count = CW'(ACCESS_CYCLES);
          next_state = S_SAMPLE;
        end
      end
      S_DONE: begin
        next_done = 1'b1;
        next_ce_n = 1'b1;
        next_oe_n = 1'b1;
        next_vpp = 1'b0;
        next_id_voltage = 1'b0;
        next_data_oe = 1'b0;
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
      count <= '0;
      iter <= 4'h0;
      phase <= 2'h0;
      op <= UVPA_CMD_READ;
      conv <= 1'b0;
      wbyte <= 8'h00;
      maker <= 8'h00;
      cmd_ready <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      status <= UVPA_OK;
      addr <= '0;
      id_voltage <= 1'b0;
      chip_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      program_strobe_n <= 1'b1;
      programming_supply <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      iter <= next_iter;
      phase <= next_phase;
      op <= next_op;
      conv <= next_conv;
      wbyte <= next_wbyte;
      maker <= next_maker;
      cmd_ready <= next_cmd_ready;
      done <= next_done;
      rdata <= next_rdata;
      status <= next_status;
      addr <= next_addr;
      id_voltage <= next_id_voltage;
      chip_enable_n <= next_ce_n;
      output_enable_n <= next_oe_n;
      program_strobe_n <= next_pgm_n;
      programming_supply <= next_vpp;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
    end
  end
endmodule

//--- verif/uvpa_host_assertions.sv
`timescale 1ns/1ps
module uvpa_host_checker
  import uvpa_pkg::*;
#(
  parameter int ADDR_WIDTH = 14,
  parameter int PULSE_LEN = PULSE_CYCLES,
  parameter int CONV_LEN = CONV_PULSE_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic done,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic id_voltage,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic program_strobe_n,
  input wire logic programming_supply,
  input wire logic data_oe
);
  int low_cnt;
  int next_low_cnt;
  int units;
  int next_units;
  logic prev_n;
  logic rise;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  assign rise = program_strobe_n && !prev_n;
  // strobe low length and count of one-unit pulses per byte
  always_comb begin
    next_low_cnt = program_strobe_n ? 0 : low_cnt + 1;
    next_units = units;
    if (!programming_supply) begin
      next_units = 0;
    end else if (rise && low_cnt == PULSE_LEN) begin
      next_units = units + 1;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      low_cnt <= 0;
      units <= 0;
      prev_n <= 1'b1;
    end else begin
      low_cnt <= next_low_cnt;
      units <= next_units;
      prev_n <= program_strobe_n;
    end
  end
  ////////////////////////////////////////
  oe_host_a: assert property (!output_enable_n |-> !data_oe && program_strobe_n)
    else $error("host drives data while device outputs enabled");
  prog_pins_a: assert property (!program_strobe_n |-> !chip_enable_n && output_enable_n
    && programming_supply && data_oe)
    else $error("program strobe without program mode pins");
  pulse_len_a: assert property (rise |-> low_cnt == PULSE_LEN || low_cnt == CONV_LEN
    || low_cnt == OVER_FACTOR * units * PULSE_LEN)
    else $error("program pulse of wrong length");
  pulse_max_a: assert property (units <= MAX_PULSES)
    else $error("too many program pulses on one byte");
  ident_pins_a: assert property (id_voltage |-> !programming_supply
    && addr[ADDR_WIDTH-1:ID_ADDR_BIT+1] == '0 && addr[ID_ADDR_BIT-1:1] == '0)
    else $error("identification entered with wrong pins");
  supply_setup_a: assert property ($rose(programming_supply) |-> program_strobe_n[*8])
    else $error("strobe too soon after supply rise");
  done_supply_a: assert property (done |-> !programming_supply)
    else $error("result given before supply back at normal");
  verify_after_a: assert property (rise |-> ##[1:100] !output_enable_n)
    else $error("no read back after pulse");
  cover property (rise && low_cnt == CONV_LEN);
  cover property (rise && units > 1 && low_cnt != PULSE_LEN);
  cover property (units == MAX_PULSES);
endmodule

//--- verif/uvpa_eprom_model.sv
`timescale 1ns/1ps
module uvpa_eprom_model
  import uvpa_pkg::*;
#(
  parameter int ADDR_WIDTH = 14,
  parameter logic [7:0] MAKER = 8'h26, // arbitrary value
  parameter logic [7:0] PRODUCT = 8'h31 // arbitrary value
) (
  input wire logic clock,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic id_voltage,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic program_strobe_n,
  input wire logic programming_supply,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic bad_id,
  input wire logic [7:0] need,
  output logic [7:0] data_in
);
  logic [7:0] mem [2**ADDR_WIDTH];
  logic [7:0] last = ERASED_BYTE;
  logic [7:0] word;
  logic [7:0] pd = '0;
  logic [ADDR_WIDTH-1:0] pa = '0;
  logic on;
  logic pend = 1'b0;
  int hits = 0;
  initial begin
    foreach (mem[i]) mem[i] = ERASED_BYTE;
  end
  assign on = !chip_enable_n && !output_enable_n && program_strobe_n;
  assign word = id_voltage ? (addr[0] ? PRODUCT ^ {7'h00, bad_id} : MAKER) : mem[addr];
  // floating bus shows the inverse of the last driven byte
  assign data_in = on ? word : ~last;
  always @(posedge clock) begin
    if (on) last <= word;
    if (!programming_supply) hits <= 0;
    if (!chip_enable_n && output_enable_n && !program_strobe_n && programming_supply
        && data_oe) begin
      pend <= 1'b1;
      pa <= addr;
      pd <= data_out;
    end else if (pend) begin
      pend <= 1'b0;
      hits <= hits + 1;
      if (hits + 1 >= need) mem[pa] <= mem[pa] & pd;
    end
  end
endmodule

//--- verif/uvpa_host_tb.sv
`timescale 1ns/1ps
module uvpa_host_tb;
  import uvpa_pkg::*;
  localparam int AW = 14;
  localparam logic [7:0] MAKER = 8'h26; // arbitrary value
  localparam logic [7:0] PRODUCT = 8'h31; // arbitrary value
  logic clock = 0, reset = 1, cmd_valid = 0, cmd_conventional = 0, bad_id = 0;
  uvpa_cmd_e cmd = UVPA_CMD_READ;
  logic [AW-1:0] cmd_addr = '0, addr;
  logic [7:0] cmd_data = '0, need = 8'h01, rdata, data_out, data_in;
  int mismatches = 0, compares = 0;
  logic cmd_ready, done, id_voltage, chip_enable_n, output_enable_n, program_strobe_n;
  logic programming_supply, data_oe;
  uvpa_status_e status;
  logic [7:0] shadow [int];
  always #50 clock = ~clock;
  uvpa_host #(.ADDR_WIDTH(AW), .PULSE_LEN(20), .CONV_LEN(100), .EXPECT_MAKER(MAKER),
    .EXPECT_PRODUCT(PRODUCT)) DUT (.clock(clock), .reset(reset), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_conventional(cmd_conventional), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .done(done), .rdata(rdata), .status(status), .addr(addr),
    .id_voltage(id_voltage), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
    .program_strobe_n(program_strobe_n), .programming_supply(programming_supply),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  uvpa_eprom_model #(.ADDR_WIDTH(AW), .MAKER(MAKER), .PRODUCT(PRODUCT)) dev (.clock(clock),
    .addr(addr), .id_voltage(id_voltage), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .program_strobe_n(program_strobe_n),
    .programming_supply(programming_supply), .data_out(data_out), .data_oe(data_oe),
    .bad_id(bad_id), .need(need), .data_in(data_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic run(input uvpa_cmd_e c, input logic [AW-1:0] a, input logic [7:0] d,
                     input logic conv);
    int n;
    n = 0;
    do begin @(posedge clock); #1; n++; end while (cmd_ready !== 1'b1 && n < 100);
    if (cmd_ready !== 1'b1) mismatches++;
    cmd = c;
    cmd_addr = a;
    cmd_data = d;
    cmd_conventional = conv;
    cmd_valid = 1;
    @(posedge clock);
    #1 cmd_valid = 0;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin @(posedge clock); #1; n++; end
    if (n >= 5000) mismatches++;
  endtask
  function automatic logic [7:0] stored(input int a);
    return shadow.exists(a) ? shadow[a] : ERASED_BYTE;
  endfunction
  function automatic uvpa_status_e blank_exp(input int a);
    return stored(a) == ERASED_BYTE ? UVPA_OK : UVPA_FAIL_VERIFY;
  endfunction
  function automatic logic takes(input int n, input logic conv);
    return conv ? n <= 1 : n <= MAX_PULSES;
  endfunction
  task automatic prog(input logic [AW-1:0] a, input logic [7:0] d, input int n,
                      input logic conv);
    logic [7:0] old;
    uvpa_status_e exp;
    old = stored(a);
    exp = (takes(n, conv) && (old & d) == d) ? UVPA_OK : UVPA_FAIL_VERIFY;
    need = 8'(n);
    run(UVPA_CMD_PROGRAM, a, d, conv);
    check(8'(status), 8'(exp));
    if (takes(n, conv)) shadow[a] = old & d;
    run(UVPA_CMD_READ, a, 8'h00, 1'b0);
    check(rdata, stored(a));
  endtask
  initial begin
    void'($urandom(32'h2619));
    repeat (20) @(posedge clock);
    #1 reset = 0;
    repeat (4) begin
      run(UVPA_CMD_BLANK, AW'($urandom), 8'h00, 1'b0);
      check(rdata, 8'hff);
      check(8'(status), 8'(UVPA_OK));
    end
    $display("test blank done");
    run(UVPA_CMD_IDENT, '0, 8'h00, 1'b0);
    check(8'(status), 8'(UVPA_OK));
    check(rdata, PRODUCT);
    bad_id = 1;
    run(UVPA_CMD_IDENT, '0, 8'h00, 1'b0);
    check(8'(status), 8'(UVPA_FAIL_IDENT));
    bad_id = 0;
    $display("test ident done");
    prog('0, 8'h00, 1, 1'b0);
    prog('1, 8'h5a, MAX_PULSES, 1'b0);
    prog(AW'(1), 8'h3c, MAX_PULSES + 1, 1'b0);
    prog('1, 8'ha5, 1, 1'b0);
    prog(AW'(3), 8'h81, 1, 1'b1);
    prog(AW'(4), 8'h7e, 2, 1'b1);
    repeat (6) prog(AW'($urandom), 8'($urandom), $urandom_range(1, 16), 1'($urandom));
    $display("test program done");
    need = 8'h63;
    repeat (2) @(posedge clock);
    #1 cmd = UVPA_CMD_PROGRAM;
    cmd_addr = AW'(5);
    cmd_valid = 1;
    @(posedge clock);
    #1 cmd_valid = 0;
    repeat (30) @(posedge clock);
    #1 reset = 1;
    #1 check(8'({chip_enable_n, program_strobe_n, programming_supply, data_oe}), 8'h0c);
    repeat (3) @(posedge clock);
    #1 reset = 0;
    run(UVPA_CMD_BLANK, AW'(5), 8'h00, 1'b0);
    check(rdata, stored(5));
    check(8'(status), 8'(blank_exp(5)));
    run(UVPA_CMD_BLANK, '1, 8'h00, 1'b0);
    check(rdata, stored(2 ** AW - 1));
    check(8'(status), 8'(blank_exp(2 ** AW - 1)));
    $display("test abort done");
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    summarize();
  end
endmodule
bind uvpa_host uvpa_host_checker #(.ADDR_WIDTH(ADDR_WIDTH), .PULSE_LEN(PULSE_LEN),
  .CONV_LEN(CONV_LEN)) watch (.clock(clock), .reset(reset), .done(done), .addr(addr),
  .id_voltage(id_voltage), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
  .program_strobe_n(program_strobe_n), .programming_supply(programming_supply),
  .data_oe(data_oe));
